// ### pwm_and_tuning_pwm.sv
/*
 * Bank of eight 6-bit modulators and one 14-bit tuning modulator, with a
 * plain register port (read data one cycle after the read strobe).
 * Assumes one clock mclk_i at 200 MHz, asynchronous active-low reset,
 * and external low-pass networks on the outputs.
 */
// Chosen here: the address map and the plain strobed port.
`include "pwm_cfg.svh"

// How it works
// - eight channels, each with 6-bit count
// - small channel period fixed, 64 steps
// - high for count steps, then low
// - channel pulses only while enabled
// - count field sits in bits 5..0
// - one tuning modulator, 14-bit value
// - tuning period is 128 steps
// - tuning pulses only while its enable set
// - top seven bits give base high steps
// - low seven bits extend periods per 128
// - new value applies on high write
module pwm_and_tuning_pwm
    import pwm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic [3:0] addr_i,
    input  wire reg_data_t  wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output reg_data_t       rdata_o,
    output logic [7:0]      pwm_o,
    output logic            tune_o
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // map a bus address onto a register
    function automatic reg_sel_t decode_addr(input logic [3:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (!a[3]) begin
            s = SEL_CHAN;
        end else begin
            unique case (a)
                `ADDR_TUNE_LOW:  s = SEL_TUNE_LOW;
                `ADDR_TUNE_HIGH: s = SEL_TUNE_HIGH;
                `ADDR_STAT_PWM:  s = SEL_STAT_PWM;
                `ADDR_STAT_TUNE: s = SEL_STAT_TUNE;
                default:         s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // reverse seven bits so extensions spread over the frame
    function automatic logic [6:0] bit_rev7(input logic [6:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int k = 0; k < 7; k++) begin
            r[k] = v[6 - k];
        end
        return r;
    endfunction

    localparam logic [6:0] PHASE_LAST = 7'(`TUNE_PERIOD_STEPS - 1);

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    reg_data_t   chan_ctrl [8];       // channel control registers
    reg_data_t   next_chan_ctrl [8];
    logic [6:0]  tune_low_stage;      // low half waiting for high write
    logic [6:0]  next_tune_low_stage;
    tune_value_t tune_value;          // value the tuning output uses
    tune_value_t next_tune_value;
    logic        tune_enable;         // tuning enable bit
    logic        next_tune_enable;
    reg_data_t   next_rdata;
    reg_sel_t    wr_sel;              // register hit by a write
    reg_sel_t    rd_sel;              // register hit by a read
    // time base state, declared here since the status read uses phase
    logic        step_en;             // one pulse per time step
    logic [6:0]  phase;               // step within the tuning period
    logic [6:0]  next_phase;
    logic [6:0]  frame;               // tuning period within a group
    logic [6:0]  next_frame;

    // decode strobes, update registers and build read data
    always_comb begin
        wr_sel              = decode_addr(addr_i);
        rd_sel              = decode_addr(addr_i);
        next_chan_ctrl      = chan_ctrl;
        next_tune_low_stage = tune_low_stage;
        next_tune_value     = tune_value;
        next_tune_enable    = tune_enable;
        next_rdata          = 8'h00;
        if (wr_i) begin
            unique case (wr_sel)
                SEL_CHAN: begin
                    next_chan_ctrl[addr_i[2:0]] = wdata_i & 8'hBF;
                end
                SEL_TUNE_LOW: begin
                    next_tune_low_stage = wdata_i[`TUNE_FIELD_MSB:0];
                end
                SEL_TUNE_HIGH: begin
                    next_tune_value  = {wdata_i[`TUNE_FIELD_MSB:0],
                                        tune_low_stage};
                    next_tune_enable = wdata_i[`TUNE_EN_BIT];
                end
                default: begin
                    // status and unmapped writes are ignored
                end
            endcase
        end
        if (rd_i) begin
            unique case (rd_sel)
                SEL_CHAN:      next_rdata = chan_ctrl[addr_i[2:0]];
                SEL_TUNE_LOW:  next_rdata = {1'b0, tune_low_stage};
                SEL_TUNE_HIGH: next_rdata = {tune_enable, tune_value[13:7]};
                SEL_STAT_PWM:  next_rdata = pwm_o;
                SEL_STAT_TUNE: next_rdata = {tune_o, phase};
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    // register the bus-facing state
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int k = 0; k < 8; k++) begin
                chan_ctrl[k] <= `CTRL_RESET;
            end
            tune_low_stage <= `TUNE_HALF_RESET;
            tune_value     <= 14'h0000;
            tune_enable    <= 1'b0;
            rdata_o        <= 8'h00;
        end else begin
            chan_ctrl      <= next_chan_ctrl;
            tune_low_stage <= next_tune_low_stage;
            tune_value     <= next_tune_value;
            tune_enable    <= next_tune_enable;
            rdata_o        <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    // step divider
    step_divider u_step (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .step_en_o (step_en)
    );

    always_comb begin
        next_phase = phase;
        next_frame = frame;
        if (step_en) begin
            next_phase = (phase == PHASE_LAST) ? 7'h00 : phase + 7'h01;
            if (phase == PHASE_LAST) begin
                next_frame = frame + 7'h01;
            end
        end
    end

    // register the time base
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase <= 7'h00;
            frame <= 7'h00;
        end else begin
            phase <= next_phase;
            frame <= next_frame;
        end
    end

    // ---------------------------------------------------------------
    // small modulators
    // ---------------------------------------------------------------
    // eight channels
    for (genvar g = 0; g < 8; g++) begin : gen_chan
        pwm_channel u_chan (
            .mclk_i       (mclk_i),
            .reset_n_i    (reset_n_i),
            .enable_i     (chan_ctrl[g][`CTRL_EN_BIT]),
            .high_count_i (chan_ctrl[g][`CTRL_CNT_MSB:0]),
            .phase_i      (phase[5:0]),
            .pwm_o        (pwm_o[g])
        );
    end

    // ---------------------------------------------------------------
    // tuning modulator
    // ---------------------------------------------------------------
    logic       tune_extend;  // this period gets one extra step
    logic [7:0] tune_high;    // high steps in this period
    logic       next_tune;

    always_comb begin
        tune_extend = bit_rev7(frame) < tune_value[6:0];
        tune_high   = {1'b0, tune_value[13:7]} + {7'h00, tune_extend};
        next_tune   = tune_enable && ({1'b0, phase} < tune_high);
    end

    // register the tuning output
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tune_o <= 1'b0;
        end else begin
            tune_o <= next_tune;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_tune_low_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (wr_i && addr_i == `ADDR_TUNE_LOW) |=> $stable(tune_value))
        else $error("low write changed tuning value");

    chk_tune_high_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (wr_i && addr_i == `ADDR_TUNE_HIGH) |=>
        tune_value == {$past(wdata_i[6:0]), $past(tune_low_stage)})
        else $error("high write did not load whole value");

    chk_tune_disabled: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !tune_enable |=> !tune_o)
        else $error("disabled tuning output not low");

    chk_phase_wrap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (step_en && phase == 7'h7F) |=> (phase == 7'h00 &&
        frame == $past(frame) + 7'h01))
        else $error("phase or frame did not wrap");

    chk_phase_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !step_en |=> $stable(phase))
        else $error("phase moved without step");

    chk_small_disabled: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !chan_ctrl[0][7] |=> !pwm_o[0])
        else $error("disabled channel zero not low");

    chk_tune_full_low: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (tune_value == 14'h0000) |=> !tune_o)
        else $error("zero tuning value went high");

    chk_tune_extend: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (tune_enable && tune_value[6:0] == 7'h7F && frame != 7'h7F &&
         phase == tune_value[13:7] && !step_en) |=> tune_o)
        else $error("extended step missing");

    chk_rdata_ctrl: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_i && !wr_i && !addr_i[3]) |=> rdata_o == $past(chan_ctrl[addr_i[2:0]]))
        else $error("control readback wrong");

    // read data stand for one cycle only, zero otherwise
    chk_rdata_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero when idle");

    chk_low_rd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `ADDR_TUNE_LOW) |=>
        rdata_o == {1'b0, $past(tune_low_stage)})
        else $error("staged low readback wrong");

    chk_tune_high_rd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `ADDR_TUNE_HIGH) |=>
        rdata_o == {$past(tune_enable), $past(tune_value[13:7])})
        else $error("tuning high readback wrong");

    chk_stat_pwm_rd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `ADDR_STAT_PWM) |=> rdata_o == $past(pwm_o))
        else $error("output status readback wrong");

    chk_stat_tune_rd: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `ADDR_STAT_TUNE) |=> rdata_o[7] == $past(tune_o))
        else $error("tuning status readback wrong");

    // the frame index only moves at a period wrap
    chk_frame_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !(step_en && phase == 7'h7F) |=> $stable(frame))
        else $error("frame moved inside a period");

    chk_tune_base_high: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (tune_enable && phase < tune_value[13:7]) |=> tune_o)
        else $error("tuning output low inside base time");

    cov_tune_extended: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        tune_enable && tune_extend && tune_o);
    cov_chan_high: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        $rose(pwm_o[0]));
    cov_high_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        wr_i && addr_i == `ADDR_TUNE_HIGH);
    cov_frame_wrap: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        step_en && phase == 7'h7F);
    cov_chan_off_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        wr_i && !addr_i[3] && !wdata_i[7]);

endmodule

// ### pwm_cfg.svh
/*
 * Constants of the modulator bank: register offsets, field positions,
 * reset values and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MCLK_PERIOD_PS      5000
// one time step: four cycles of a 12 MHz clock, rounded up to 67 cycles of the 200 MHz core clock, in ps
`define PWM_STEP_PS         333333
`define PWM_STEP_CYCLES     ((`PWM_STEP_PS + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
// periods, in hundredths of a microsecond, then in steps and in periods
`define SMALL_PERIOD_CUS    2133
`define TUNE_PERIOD_CUS     4266
`define SMALL_PERIOD_STEPS  64
`define TUNE_PERIOD_STEPS   128
`define TUNE_FRAME_PERIODS  128

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_TUNE_LOW       4'h8
`define ADDR_TUNE_HIGH      4'h9
`define ADDR_STAT_PWM       4'hA
`define ADDR_STAT_TUNE      4'hB

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_EN_BIT         7
`define CTRL_CNT_MSB        5
`define TUNE_EN_BIT         7
`define TUNE_FIELD_MSB      6
`define CTRL_RESET          8'h00
`define TUNE_HALF_RESET     7'h00

`endif

// ### pwm_pkg.sv
/*
 * Types shared by the modulator bank.
 * Assumes pwm_cfg.svh is available for the constants.
 */
package pwm_pkg;

    // ---------------------------------------------------------------
    // data types
    // ---------------------------------------------------------------
    typedef logic [5:0]  pwm_count_t;   // small modulator high count
    typedef logic [13:0] tune_value_t;  // tuning modulator value
    typedef logic [7:0]  reg_data_t;    // register bus data

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_CHAN      = 3'b000,
        SEL_TUNE_LOW  = 3'b001,
        SEL_TUNE_HIGH = 3'b010,
        SEL_STAT_PWM  = 3'b011,
        SEL_STAT_TUNE = 3'b100,
        SEL_NONE      = 3'b101
    } reg_sel_t;

endpackage

// ### step_divider.sv
/*
 * Time step divider: one-cycle enable pulse once per modulator step.
 * Assumes a single clock mclk_i and an asynchronous active-low reset.
 */
`include "pwm_cfg.svh"

module step_divider
    import pwm_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    output logic      step_en_o
);

    // ---------------------------------------------------------------
    // divider
    // ---------------------------------------------------------------
    localparam logic [6:0] STEP_LAST = 7'(`PWM_STEP_CYCLES - 1);
    localparam int         STEP_N    = `PWM_STEP_CYCLES;

    logic [6:0] div_count;       // cycles into the current step
    logic [6:0] next_div_count;
    logic       next_step_en;

    // count cycles and pulse on the last one
    always_comb begin
        next_step_en = (div_count == STEP_LAST);
        if (next_step_en) begin
            next_div_count = 7'h00;
        end else begin
            next_div_count = div_count + 7'h01;
        end
    end

    // register divider state
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_count <= 7'h00;
            step_en_o <= 1'b0;
        end else begin
            div_count <= next_div_count;
            step_en_o <= next_step_en;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // step spacing
    chk_step_spacing: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        step_en_o |=> (!step_en_o)[*8] ##[1:STEP_N] step_en_o)
        else $error("step pulse spacing wrong");

    chk_step_exact: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        step_en_o |-> ##[STEP_N:STEP_N] step_en_o)
        else $error("step period not exact");

endmodule

// ### pwm_channel.sv
/*
 * One small pulse-width modulator channel.
 * Assumes a shared step phase from the bank, one clock and async reset.
 */
`include "pwm_cfg.svh"

module pwm_channel
    import pwm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       enable_i,
    input  wire pwm_count_t high_count_i,
    input  wire pwm_count_t phase_i,
    output logic            pwm_o
);

    // ---------------------------------------------------------------
    // output stage
    // ---------------------------------------------------------------
    logic next_pwm;   // output level for the coming cycle

    always_comb begin
        next_pwm = enable_i && (phase_i < high_count_i);
    end

    // register the output level
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= next_pwm;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_chan_disabled: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !enable_i |=> !pwm_o)
        else $error("disabled channel output not low");

    chk_chan_start: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (enable_i && phase_i == 6'h00 && high_count_i != 6'h00) |=> pwm_o)
        else $error("channel not high at period start");

    chk_chan_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (high_count_i == 6'h00) |=> !pwm_o)
        else $error("zero count channel went high");

endmodule

// ### rc_integrator.sv
/*
 * Behavioural model of the external low-pass integration network that
 * sits on one modulator output: it gathers charge while the line is high.
 * Assumes the output is a registered level, sampled on rising mclk_i.
 */
module rc_integrator (
    input  wire logic        mclk_i,
    input  wire logic        level_i,
    output logic [31:0]      charge_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ---------------------------------------------------------------
    // charge store
    // ---------------------------------------------------------------
    // starts empty; an unknown level spoils the charge on purpose
    initial charge_o = 32'h0;

    // one unit of charge for each clock the line stays high
    always @(posedge mclk_i) begin
        charge_o <= charge_o + {31'h0, level_i};
    end
endmodule

// ### tb.sv
/*
 * Self-checking bench of the modulator bank: register tasks, duty checks
 * through integration network models on every output.
 * Assumes the design files and rc_integrator.sv are compiled before it.
 */
`include "pwm_cfg.svh"

// compare two values, count it, report a mismatch at once
`define CHK(name, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("CHECK FAILED %s exp %0h got %0h", name, exp, got); \
    end \
end

module tb
    import pwm_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // ---------------------------------------------------------------
    // timing figures
    // ---------------------------------------------------------------
    localparam int STEP = `PWM_STEP_CYCLES;         // clocks a step
    localparam int SP   = STEP * `SMALL_PERIOD_STEPS; // small period
    localparam int TP   = STEP * `TUNE_PERIOD_STEPS;  // tuning period

    logic        mclk    = 1'b0;   // core clock
    logic        reset_n = 1'b0;   // async reset, active low
    logic [3:0]  addr    = 4'h0;   // register address
    reg_data_t   wdata   = 8'h00;  // write data
    logic        wr      = 1'b0;   // write strobe
    logic        rd      = 1'b0;   // read strobe
    reg_data_t   rdata;            // read data
    logic [7:0]  pwm;              // small outputs
    logic        tune;             // tuning output
    logic [31:0] charge [9];       // network charge, 8 = tuning
    int          errors     = 0;   // mismatches
    int          num_checks = 0;   // comparisons
    reg_data_t   rv;               // last read value
    logic [31:0] got [9];          // measured high clocks, unknown kept
    int          cnt [8] = '{1, 0, 2, 31, 32, 62, 63, 17}; // counts

    // ---------------------------------------------------------------
    // clock, design and partner models
    // ---------------------------------------------------------------
    always #2.5 mclk = ~mclk;

    pwm_and_tuning_pwm i_dut (
        .mclk_i    (mclk),
        .reset_n_i (reset_n),
        .addr_i    (addr),
        .wdata_i   (wdata),
        .wr_i      (wr),
        .rd_i      (rd),
        .rdata_o   (rdata),
        .pwm_o     (pwm),
        .tune_o    (tune)
    );

    // one integration network on each output
    for (genvar g = 0; g < 9; g++) begin : g_net
        rc_integrator i_net (
            .mclk_i   (mclk),
            .level_i  ((g < 8) ? pwm[g % 8] : tune),
            .charge_o (charge[g])
        );
    end

    // ---------------------------------------------------------------
    // register bus tasks
    // ---------------------------------------------------------------
    // one-cycle write strobe beside address and data
    task automatic wr_reg(input logic [3:0] a, input reg_data_t d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // one-cycle read strobe; data stand in the following cycle only
    task automatic rd_reg(input logic [3:0] a);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 rv = rdata;
    endtask

    // high clocks seen by every network over n clocks
    task automatic measure(input int n);
        logic [31:0] start [9];
        @(posedge mclk);
        #1 foreach (start[g]) start[g] = charge[g];
        repeat (n) @(posedge mclk);
        #1 foreach (got[g]) got[g] = charge[g] - start[g];
    endtask

    // ---------------------------------------------------------------
    // verdict
    // ---------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // cuts a hang short
    initial begin
        repeat (90000) @(posedge mclk);
        errors++;
        end_of_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        // channel and tuning registers start cleared; unmapped reads give zero
        for (int a = 0; a < 10; a++) begin
            rd_reg(4'(a));
            `CHK("reset value", 8'h00, rv)
        end
        wr_reg(4'hC, 8'hFF);
        rd_reg(4'hC);
        `CHK("unmapped", 8'h00, rv)
        // program all channels, bit 6 set to see it dropped
        for (int g = 0; g < 8; g++) begin
            wr_reg(4'(g), {(g != 7), 1'b1, 6'(cnt[g])});
        end
        for (int g = 0; g < 8; g++) begin
            rd_reg(4'(g));
            `CHK("chan ctrl", {(g != 7), 1'b0, 6'(cnt[g])}, rv)
        end
        // duty over one full period, whatever the phase
        measure(SP);
        for (int g = 0; g < 8; g++) begin
            `CHK("chan high", (g == 7) ? 0 : cnt[g] * STEP, got[g])
        end
        // tuning base only, low part zero
        wr_reg(`ADDR_TUNE_LOW, 8'h00);
        wr_reg(`ADDR_TUNE_HIGH, 8'h85);
        rd_reg(`ADDR_TUNE_HIGH);
        `CHK("tune high rd", 8'h85, rv)
        measure(TP);
        `CHK("tune base", 5 * STEP, got[8])
        // low write alone must not change the output
        wr_reg(`ADDR_TUNE_LOW, 8'h7F);
        measure(TP);
        `CHK("tune staged", 5 * STEP, got[8])
        rd_reg(`ADDR_TUNE_LOW);
        `CHK("tune low rd", 8'h7F, rv)
        wr_reg(`ADDR_TUNE_HIGH, 8'h85);
        measure(TP);
        `CHK("tune extended", 6 * STEP, got[8])
        // half the periods extended, alternating
        wr_reg(`ADDR_TUNE_LOW, 8'h40);
        wr_reg(`ADDR_TUNE_HIGH, 8'h85);
        measure(2 * TP);
        `CHK("tune spread", 11 * STEP, got[8])
        // clear enables: outputs held low
        wr_reg(`ADDR_TUNE_HIGH, 8'h05);
        for (int g = 0; g < 8; g++) begin
            wr_reg(4'(g), {2'b00, 6'(cnt[g])});
        end
        measure(TP);
        `CHK("tune off", 0, got[8])
        for (int g = 0; g < 8; g++) begin
            `CHK("chan off", 0, got[g])
        end
        rd_reg(`ADDR_STAT_PWM);
        `CHK("pwm status", 8'h00, rv)
        `CHK("tune pin", 1'b0, tune)
        rd_reg(`ADDR_STAT_TUNE);
        `CHK("tune status", 1'b0, rv[7])
        end_of_test();
    end
endmodule
